/* File: logic/coarse_phase_pkg.sv */
// How it works
// - Per-output coarse shift in synth clock periods
// - Shortened period never below 2 high 2 low
// - Up to 2^31 cycles per request, signed 32-bit shift
// - Positive lengthens, negative shortens, one period
// - Even duty splits change across both phases
// - Custom high width: change goes to low only
// - Unlimited successive independent requests
// - Buffer is one differential or two single-ended
// - Two-bit swing code selects differential swing
// - Three-bit code selects eight crossing levels
// - Single-ended copies, complementary pad optionally inverted
// - Five supply levels, four impedances single-ended
//
package coarse_phase_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DIVIDE     = 8'h00;
  localparam logic [7:0] ADDR_HIGH_WIDTH = 8'h04;
  localparam logic [7:0] ADDR_SHIFT      = 8'h08;
  localparam logic [7:0] ADDR_BUF_CTRL   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;

  // Buffer control field positions
  localparam int SE_MODE_BIT    = 0;
  localparam int INVERT_BIT     = 1;
  localparam int SUPPLY_LSB     = 2;
  localparam int SWING_LSB      = 5;
  localparam int CROSS_LSB      = 7;
  localparam int IMPEDANCE_LSB  = 10;
  localparam int BUF_CTRL_WIDTH = 12;

  // Reset values
  localparam logic [31:0] DIVIDE_RESET     = 32'h0000_0008;
  localparam logic [31:0] HIGH_WIDTH_RESET = 32'h0000_0000;
  localparam logic [11:0] BUF_CTRL_RESET   = 12'h000;

  // Smallest phase length after shortening, in synth cycles
  localparam logic [32:0] MIN_PHASE        = 33'h0_0000_0002;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic        se_mode;
    logic        invert_comp;
    logic [2:0]  supply_level_select;
    logic [1:0]  swing_select;
    logic [2:0]  common_mode_select;
    logic [1:0]  impedance_select;
  } buf_cfg_type;

  typedef struct packed {
    logic [31:0] divide;
    logic [31:0] high_width;
    logic [31:0] shift;
    logic        shift_req;
  } div_cfg_type;

endpackage

/* File: logic/coarse_divider.sv */
module coarse_divider
  import coarse_phase_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire div_cfg_type cfg,
  output logic             clk_out,
  output logic             shift_taken,
  output logic             shift_busy
);

  typedef enum logic [1:0] {PH_HIGH, PH_LOW} phase_type;

  typedef struct packed {
    phase_type   phase;
    logic [32:0] count;
    logic [32:0] high_len;
    logic [32:0] low_len;
    logic        pending;
    logic        out;
    logic        taken;
    logic        busy;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic [32:0] norm_high;
  logic [32:0] norm_low;
  logic [33:0] sh;
  logic [33:0] sh_hi;
  logic [33:0] sh_lo;
  logic [33:0] adj_high;
  logic [33:0] adj_low;

  // ----------------------------------------------------------------
  // Phase lengths
  // ----------------------------------------------------------------
  always_comb
  begin
    if (cfg.high_width == 32'h0)
    begin
      norm_high = {2'b00, cfg.divide[31:1]};
    end
    else
    begin
      norm_high = {1'b0, cfg.high_width};
    end
    norm_low = {1'b0, cfg.divide} - norm_high;
    sh = {{2{cfg.shift[31]}}, cfg.shift};
    if (cfg.high_width == 32'h0)
    begin
      sh_hi = {sh[33], sh[33:1]};
      sh_lo = sh - sh_hi;
    end
    else
    begin
      sh_hi = 34'h0;
      sh_lo = sh;
    end
    adj_high = {1'b0, norm_high} + sh_hi;
    adj_low  = {1'b0, norm_low} + sh_lo;
    // Clamp: a negative or tiny result pins at the floor
    if (adj_high[33] || adj_high[32:0] < MIN_PHASE)
    begin
      adj_high = {1'b0, MIN_PHASE};
    end
    if (adj_low[33] || adj_low[32:0] < MIN_PHASE)
    begin
      adj_low = {1'b0, MIN_PHASE};
    end
  end

  // ----------------------------------------------------------------
  // Divider state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.taken = 1'b0;
    if (cfg.shift_req)
    begin
      s_d.pending = 1'b1;
    end
    if (s_q.count > 33'h1)
    begin
      s_d.count = s_q.count - 33'h1;
    end
    else if (s_q.phase == PH_HIGH)
    begin
      s_d.phase = PH_LOW;
      s_d.out   = 1'b0;
      s_d.count = s_q.low_len;
    end
    else
    begin
      // Period boundary: take a pending shift once, else plain division
      s_d.phase = PH_HIGH;
      s_d.out   = 1'b1;
      if (s_q.pending && !cfg.shift_req)
      begin
        s_d.high_len = adj_high[32:0];
        s_d.low_len  = adj_low[32:0];
        s_d.pending  = 1'b0;
        s_d.taken    = 1'b1;
        s_d.busy     = 1'b1;
      end
      else
      begin
        s_d.high_len = norm_high;
        s_d.low_len  = norm_low;
        s_d.busy     = 1'b0;
      end
      s_d.count = s_d.high_len;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '{phase: PH_HIGH, count: 33'h1, high_len: 33'h4, low_len: 33'h4,
               pending: 1'b0, out: 1'b0, taken: 1'b0, busy: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign clk_out     = s_q.out;
  assign shift_taken = s_q.taken;
  assign shift_busy  = s_q.busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Only a shifted period is floored; plain ratios below 4 run as programmed
  a_high_floor_kept: assert property (@(posedge clk) disable iff (rst)
    s_q.taken |-> s_q.high_len >= MIN_PHASE && s_q.low_len >= MIN_PHASE)
    else $error("phase shorter than floor");

  a_shift_once_only: assert property (@(posedge clk) disable iff (rst)
    s_q.taken |=> !s_q.taken)
    else $error("shift applied twice");

  a_custom_high_kept: assert property (@(posedge clk) disable iff (rst)
    (s_q.taken && cfg.high_width != 32'h0 && cfg.high_width >= 32'h2) |-> s_q.high_len == {1'b0, cfg.high_width})
    else $error("high width altered");

endmodule // coarse_divider

/* File: logic/output_coarse_phase_and_buffer_cfg.sv */
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
module output_coarse_phase_and_buffer_cfg
  import coarse_phase_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             true_pad,
  output logic             complementary_pad,
  output buf_cfg_type      buf_cfg
);

  typedef struct packed {
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    div_cfg_type div;
    logic [11:0] buf_ctrl;
    logic        true_q;
    logic        comp_q;
    logic        sticky_taken;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic clk_div;
  logic shift_taken;
  logic shift_busy;

  coarse_divider u_div (
    .clk         (clk),
    .rst         (rst),
    .cfg         (s_q.div),
    .clk_out     (clk_div),
    .shift_taken (shift_taken),
    .shift_busy  (shift_busy)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Register bus and pad logic
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.div.shift_req = 1'b0;
    if (shift_taken)
    begin
      s_d.sticky_taken = 1'b1;
    end
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      case (s_q.aw_addr)
        ADDR_DIVIDE:     s_d.div.divide = merge(s_q.div.divide, s_q.w_data, s_q.w_strb);
        ADDR_HIGH_WIDTH: s_d.div.high_width = merge(s_q.div.high_width, s_q.w_data, s_q.w_strb);
        ADDR_SHIFT:
        begin
          // Every write is a fresh request, even of the same value
          s_d.div.shift = merge(s_q.div.shift, s_q.w_data, s_q.w_strb);
          s_d.div.shift_req = 1'b1;
        end
        ADDR_BUF_CTRL:   s_d.buf_ctrl = BUF_CTRL_WIDTH'(merge({20'h0, s_q.buf_ctrl}, s_q.w_data,
                                                          s_q.w_strb));
        ADDR_STATUS:
        begin
          // Write one clears; a same-cycle event wins
          if (s_q.w_strb[0] && s_q.w_data[0] && !shift_taken)
          begin
            s_d.sticky_taken = 1'b0;
          end
        end
        default:         s_d.bresp = RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_DIVIDE:     s_d.rdata = s_q.div.divide;
        ADDR_HIGH_WIDTH: s_d.rdata = s_q.div.high_width;
        ADDR_SHIFT:      s_d.rdata = s_q.div.shift;
        ADDR_BUF_CTRL:   s_d.rdata = {20'h0, s_q.buf_ctrl};
        ADDR_STATUS:     s_d.rdata = {29'h0, clk_div, shift_busy, s_q.sticky_taken};
        default:
        begin
          s_d.rdata = 32'h0;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    // Single-ended: comp pad copies the clock, inverted if INVERT_BIT is set; differential: complement
    s_d.true_q = clk_div;
    if (s_q.buf_ctrl[SE_MODE_BIT])
    begin
      s_d.comp_q = s_q.buf_ctrl[INVERT_BIT] ? !clk_div : clk_div;
    end
    else
    begin
      s_d.comp_q = !clk_div;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.div.divide     <= DIVIDE_RESET;
      s_q.div.high_width <= HIGH_WIDTH_RESET;
      s_q.buf_ctrl       <= BUF_CTRL_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready     = !s_q.aw_have;
  assign s_axi_wready      = !s_q.w_have;
  assign s_axi_bvalid      = s_q.bvalid;
  assign s_axi_bresp       = s_q.bresp;
  assign s_axi_arready     = !s_q.rvalid;
  assign s_axi_rvalid      = s_q.rvalid;
  assign s_axi_rdata       = s_q.rdata;
  assign s_axi_rresp       = s_q.rresp;
  assign true_pad          = s_q.true_q;
  assign complementary_pad = s_q.comp_q;
  // Software keeps supply/swing/crossing combos legal; hardware passes them on
  assign buf_cfg = '{se_mode:             s_q.buf_ctrl[SE_MODE_BIT],
                     invert_comp:         s_q.buf_ctrl[INVERT_BIT],
                     supply_level_select: s_q.buf_ctrl[SUPPLY_LSB +: 3],
                     swing_select:        s_q.buf_ctrl[SWING_LSB +: 2],
                     common_mode_select:  s_q.buf_ctrl[CROSS_LSB +: 3],
                     impedance_select:    s_q.buf_ctrl[IMPEDANCE_LSB +: 2]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_diff_pads_opposite: assert property (@(posedge clk) disable iff (rst)
    !s_q.buf_ctrl[SE_MODE_BIT] |=> complementary_pad == !true_pad)
    else $error("differential pads not complementary");

  a_se_pads_copy: assert property (@(posedge clk) disable iff (rst)
    (s_q.buf_ctrl[SE_MODE_BIT] && !s_q.buf_ctrl[INVERT_BIT]) |=> complementary_pad == true_pad)
    else $error("single-ended copy differs");

  a_shift_write_req: assert property (@(posedge clk) disable iff (rst)
    (s_q.aw_have && s_q.w_have && !s_q.bvalid && s_q.aw_addr == ADDR_SHIFT) |=> s_q.div.shift_req)
    else $error("shift write lost");

  a_write_resp_next: assert property (@(posedge clk) disable iff (rst)
    (s_q.aw_have && s_q.w_have && !s_q.bvalid) |=> s_axi_bvalid)
    else $error("no write response");

  a_swing_field_out: assert property (@(posedge clk) disable iff (rst)
    buf_cfg.swing_select == s_q.buf_ctrl[SWING_LSB +: 2])
    else $error("swing field wrong");

  a_se_inverted_copy: assert property (@(posedge clk) disable iff (rst)
    (s_q.buf_ctrl[SE_MODE_BIT] && s_q.buf_ctrl[INVERT_BIT]) |=> complementary_pad == !true_pad)
    else $error("single-ended inverted copy wrong");

  a_pad_high_follows: assert property (@(posedge clk) disable iff (rst)
    clk_div |=> true_pad)
    else $error("true pad missed high phase");

  a_pad_low_follows: assert property (@(posedge clk) disable iff (rst)
    !clk_div |=> !true_pad)
    else $error("true pad missed low phase");

  // ----------------------------------------------------------------
  // Handshake steps shared by the bus checks
  // ----------------------------------------------------------------
  sequence seq_write_ready;
    s_q.aw_have && s_q.w_have && !s_q.bvalid;
  endsequence

  sequence seq_resp_waits;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  sequence seq_read_waits;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  a_bresp_held: assert property (@(posedge clk) disable iff (rst)
    seq_resp_waits |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  a_rdata_held: assert property (@(posedge clk) disable iff (rst)
    seq_read_waits |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");

  a_read_answer_next: assert property (@(posedge clk) disable iff (rst)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("no read response");

  a_write_okay: assert property (@(posedge clk) disable iff (rst)
    (seq_write_ready ##0 (s_q.aw_addr <= ADDR_STATUS && s_q.aw_addr[1:0] == 2'b00))
    |=> s_axi_bresp == RESP_OKAY)
    else $error("mapped write refused");

  a_unmapped_write_err: assert property (@(posedge clk) disable iff (rst)
    (seq_write_ready ##0 (s_q.aw_addr > ADDR_STATUS)) |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write accepted");

  a_unmapped_read_err: assert property (@(posedge clk) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_STATUS)
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");

  // ----------------------------------------------------------------
  // Register landing and status checks
  // ----------------------------------------------------------------
  // Full-strobe writes only; partial lanes go through the merge
  a_divide_write_lands: assert property (@(posedge clk) disable iff (rst)
    (seq_write_ready ##0 (s_q.aw_addr == ADDR_DIVIDE && s_q.w_strb == 4'hf))
    |=> s_q.div.divide == $past(s_q.w_data))
    else $error("divide write lost");

  a_high_write_lands: assert property (@(posedge clk) disable iff (rst)
    (seq_write_ready ##0 (s_q.aw_addr == ADDR_HIGH_WIDTH && s_q.w_strb == 4'hf))
    |=> s_q.div.high_width == $past(s_q.w_data))
    else $error("high width write lost");

  a_shift_write_lands: assert property (@(posedge clk) disable iff (rst)
    (seq_write_ready ##0 (s_q.aw_addr == ADDR_SHIFT && s_q.w_strb == 4'hf))
    |=> s_q.div.shift == $past(s_q.w_data))
    else $error("shift value lost");

  a_buf_write_lands: assert property (@(posedge clk) disable iff (rst)
    (seq_write_ready ##0 (s_q.aw_addr == ADDR_BUF_CTRL && s_q.w_strb == 4'hf))
    |=> s_q.buf_ctrl == $past(s_q.w_data[BUF_CTRL_WIDTH-1:0]))
    else $error("buffer control write lost");

  // Receivers see a configuration change only through a buffer write
  a_buf_cfg_steady: assert property (@(posedge clk) disable iff (rst)
    !(s_q.aw_have && s_q.w_have && !s_q.bvalid && s_q.aw_addr == ADDR_BUF_CTRL)
    |=> $stable(buf_cfg))
    else $error("buffer configuration moved");

  a_shift_req_pulse: assert property (@(posedge clk) disable iff (rst)
    s_q.div.shift_req |=> !s_q.div.shift_req)
    else $error("shift request longer than one cycle");

  a_sticky_set_wins: assert property (@(posedge clk) disable iff (rst)
    shift_taken |=> s_q.sticky_taken)
    else $error("applied flag not set");

  a_sticky_clear: assert property (@(posedge clk) disable iff (rst)
    (seq_write_ready ##0 (s_q.aw_addr == ADDR_STATUS && s_q.w_strb[0] && s_q.w_data[0] && !shift_taken))
    |=> !s_q.sticky_taken)
    else $error("applied flag not cleared");

  a_status_flag_read: assert property (@(posedge clk) disable iff (rst)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATUS)
    |=> s_axi_rdata[0] == $past(s_q.sticky_taken))
    else $error("applied flag read wrong");

endmodule // output_coarse_phase_and_buffer_cfg

/* File: tb/clock_receiver_model.sv */
module clock_receiver_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        true_pad,
  output logic [31:0]      high_len,
  output logic [31:0]      low_len,
  output logic [15:0]      period_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Phase length meter
  // ----------------------------------------
  // A receiver only sees the pad, so phases are timed purely from its edges
  logic [31:0] run_q;
  logic        prev_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run_q      <= 32'h0000_0000;
      prev_q     <= 1'b0;
      high_len   <= 32'h0000_0000;
      low_len    <= 32'h0000_0000;
      period_cnt <= 16'h0000;
    end
    else
    begin
      prev_q <= true_pad;
      run_q  <= run_q + 32'h0000_0001;
      if (true_pad != prev_q)
      begin
        run_q <= 32'h0000_0001;
        if (true_pad)
        begin
          low_len    <= run_q;
          period_cnt <= period_cnt + 16'h0001;
        end
        else
          high_len <= run_q;
      end
    end
  end
endmodule // clock_receiver_model

/* File: tb/test_output_coarse_phase_and_buffer_cfg.sv */
module test_output_coarse_phase_and_buffer_cfg
  import coarse_phase_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic        true_pad;
  logic        complementary_pad;
  buf_cfg_type buf_cfg;
  logic [31:0] high_len;
  logic [31:0] low_len;
  logic [15:0] period_cnt;
  int          num_errors = 0;
  int          n_checks = 0;

  always #2.5 clk = ~clk;

  output_coarse_phase_and_buffer_cfg u_output_coarse_phase_and_buffer_cfg (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .true_pad(true_pad), .complementary_pad(complementary_pad), .buf_cfg(buf_cfg));
  clock_receiver_model u_clock_receiver_model (.clk(clk), .rst(rst), .true_pad(true_pad),
    .high_len(high_len), .low_len(low_len), .period_cnt(period_cnt));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic print_verdict;
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic give_up(input string what);
    check(what, 32'h0000_0001, 32'h0000_0000);
    print_verdict();
  endtask

  // Ready is sampled mid-cycle: inputs and registers only move at rising edges
  task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] exp);
    logic a;
    logic w;
    logic b;
    int   i;
    a = 1'b0;
    w = 1'b0;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= addr;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= data;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; !(a && w); i++)
    begin
      if (i > 50)
        give_up("write handshake");
      @(negedge clk);
      if (s_axi_awready)
        a = 1'b1;
      if (s_axi_wready)
        w = 1'b1;
      @(posedge clk);
      if (a)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
    end
    for (i = 0; !b; i++)
    begin
      if (i > 50)
        give_up("write response");
      @(negedge clk);
      b = s_axi_bvalid;
    end
    check("bresp", {30'h0, exp}, {30'h0, s_axi_bresp});
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] addr, output logic [31:0] data, input logic [1:0] exp);
    logic a;
    logic r;
    int   i;
    a = 1'b0;
    r = 1'b0;
    @(posedge clk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; !a; i++)
    begin
      if (i > 50)
        give_up("read handshake");
      @(negedge clk);
      a = s_axi_arready;
      @(posedge clk);
    end
    s_axi_arvalid <= 1'b0;
    for (i = 0; !r; i++)
    begin
      if (i > 50)
        give_up("read response");
      @(negedge clk);
      r = s_axi_rvalid;
      data = s_axi_rdata;
    end
    check("rresp", {30'h0, exp}, {30'h0, s_axi_rresp});
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic next_period;
    logic [15:0] start;
    int          i;
    start = period_cnt;
    for (i = 0; period_cnt == start; i++)
    begin
      if (i > 5000)
        give_up("output period");
      @(negedge clk);
    end
  endtask

  // The period in flight at the write stays normal; the first odd one is the shifted one
  task automatic run_shift(input int s, input int eh, input int el, input int nh, input int nl);
    logic found;
    int   k;
    found = 1'b0;
    reg_wr(ADDR_SHIFT, 32'(s), RESP_OKAY);
    for (k = 0; k < 4 && !found; k++)
    begin
      next_period();
      if (high_len != 32'(nh) || low_len != 32'(nl))
        found = 1'b1;
    end
    check("shifted high", 32'(eh), high_len);
    check("shifted low", 32'(el), low_len);
    next_period();
    check("following high", 32'(nh), high_len);
    check("following low", 32'(nl), low_len);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  int          sh[10] = '{4, -4, 5, -5, -20, 1000, 6, -10, -11, -9};
  int          eh[10] = '{10, 6, 10, 5, 2, 508, 4, 4, 4, 4};
  int          el[10] = '{10, 6, 11, 6, 2, 508, 18, 2, 2, 3};
  logic [31:0] d;
  buf_cfg_type exp_cfg;
  int          k;

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reg_rd(ADDR_DIVIDE, d, RESP_OKAY);
    check("divide reset", DIVIDE_RESET, d);
    reg_rd(ADDR_HIGH_WIDTH, d, RESP_OKAY);
    check("high width reset", HIGH_WIDTH_RESET, d);
    reg_rd(ADDR_BUF_CTRL, d, RESP_OKAY);
    check("buffer reset", 32'(BUF_CTRL_RESET), d);
    reg_rd(8'h14, d, RESP_SLVERR);
    check("unmapped read", 32'h0000_0000, d);
    reg_wr(8'h14, 32'h0000_0001, RESP_SLVERR);
    next_period();
    next_period();
    check("default high", 32'h0000_0004, high_len);
    check("default low", 32'h0000_0004, low_len);
    // Differential, single-ended copy, single-ended inverted
    for (k = 0; k < 3; k++)
    begin
      reg_wr(ADDR_BUF_CTRL, (k == 0) ? 32'h0 : ((k == 1) ? 32'h1 : 32'h3), RESP_OKAY);
      repeat (12)
      begin
        @(negedge clk);
        check("comp pad", {31'h0, (k == 1) ? true_pad : ~true_pad}, {31'h0, complementary_pad});
      end
    end
    // Differential codes stay on the lowest supply code so every crossing level is legal
    for (k = 0; k < 8; k++)
    begin
      d = (k << CROSS_LSB) | ((k & 3) << SWING_LSB) | ((k & 3) << IMPEDANCE_LSB);
      reg_wr(ADDR_BUF_CTRL, d, RESP_OKAY);
      exp_cfg = '{1'b0, 1'b0, 3'h0, 2'(k), 3'(k), 2'(k)};
      check("diff cfg", 32'(exp_cfg), 32'(buf_cfg));
      reg_rd(ADDR_BUF_CTRL, d, RESP_OKAY);
      check("diff readback", 32'(k << CROSS_LSB) | 32'((k & 3) << SWING_LSB) |
            32'((k & 3) << IMPEDANCE_LSB), d);
    end
    for (k = 0; k < 5; k++)
    begin
      reg_wr(ADDR_BUF_CTRL, 32'(1 | (k << SUPPLY_LSB) | ((k & 3) << IMPEDANCE_LSB)), RESP_OKAY);
      exp_cfg = '{1'b1, 1'b0, 3'(k), 2'h0, 3'h0, 2'(k)};
      check("single cfg", 32'(exp_cfg), 32'(buf_cfg));
    end
    // Divide above 4 keeps coarse shifts legal
    reg_wr(ADDR_DIVIDE, 32'h0000_0010, RESP_OKAY);
    // Let the new ratio reach the pad before the first shift is searched for
    next_period();
    next_period();
    // Ten steps, floor-clamped and large ones included, one request at a time
    for (k = 0; k < 10; k++)
    begin
      if (k == 6)
      begin
        reg_wr(ADDR_HIGH_WIDTH, 32'h0000_0004, RESP_OKAY);
        next_period();
        next_period();
      end
      run_shift(sh[k], eh[k], el[k], (k < 6) ? 8 : 4, (k < 6) ? 8 : 12);
      if (k == 0)
      begin
        reg_rd(ADDR_STATUS, d, RESP_OKAY);
        check("shift applied flag", 32'h0000_0001, d & 32'h1);
        reg_wr(ADDR_STATUS, 32'h0000_0001, RESP_OKAY);
        reg_rd(ADDR_STATUS, d, RESP_OKAY);
        check("flag cleared", 32'h0000_0000, d & 32'h1);
      end
    end
    print_verdict();
  end
endmodule // test_output_coarse_phase_and_buffer_cfg
